// *** hw/asel_pkg.sv ***
// Purpose: Shared constants and carriers for the conversion start selector.
// Assumes: Byte offsets on the option slot are relative to the slot base.
// Notes:   Result words are signed two's complement, one per analog input.
package asel_pkg;

  // ----------------------------------------------------------------
  // Option slot write map
  // ----------------------------------------------------------------
  localparam int          ADDR_W         = 5;
  localparam logic [4:0]  OFS_START      = 5'h00;
  localparam logic [4:0]  OFS_INIT       = 5'h0C;
  localparam logic [15:0] INIT_RESET     = 16'h0000;

  // ----------------------------------------------------------------
  // Initialization word fields
  // ----------------------------------------------------------------
  localparam int          BIT_ROUTE_LO   = 8;
  localparam int          BIT_ROUTE_HI   = 9;
  localparam int          BIT_EN_A       = 10;
  localparam int          BIT_EN_B       = 11;
  localparam int          BIT_START_MODE = 14;

  // ----------------------------------------------------------------
  // Converter shape
  // ----------------------------------------------------------------
  localparam int          NUM_CH         = 4;
  localparam int          RES_W          = 12;

  typedef struct packed {
    logic              stb;
    logic [ADDR_W-1:0] addr;
    logic [15:0]       data;
  } asel_wr_s;

  typedef struct packed {
    logic [NUM_CH-1:0][RES_W-1:0] ch;
  } asel_result_s;

endpackage

// *** hw/asel_conv_seq.sv ***
// Purpose: Runs one simultaneous conversion of all inputs per start request.
// Assumes: The converter answers every start with exactly one done pulse.
// Notes:   Start requests that arrive while a conversion runs are dropped.
module asel_conv_seq #(
  parameter int CH_NUM = 4
) (
  input  wire logic                  clk_sys,
  input  wire logic                  resetn,
  input  wire logic                  startReq,
  output logic                       convStart,
  input  wire logic                  convDone,
  input  wire asel_pkg::asel_result_s convData,
  output asel_pkg::asel_result_s     results,
  output logic                       eocPulse,
  output logic                       busy
);
  import asel_pkg::*;

  typedef enum logic [0:0] {ASEL_IDLE, ASEL_WAIT} asel_state_e;

  if (CH_NUM != NUM_CH) begin : g_chk
    $error("CH_NUM must match the packed result width");
  end

  asel_state_e  state_q,    state_d;
  logic         startQ,     startD;
  logic         eocQ,       eocD;
  asel_result_s resultsQ,   resultsD;

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_comb begin
    state_d  = state_q;
    startD   = 1'b0;
    eocD     = 1'b0;
    resultsD = resultsQ;
    case (state_q)
      ASEL_IDLE: begin
        // R08: all channels together
        if (startReq) begin
          startD  = 1'b1;
          state_d = ASEL_WAIT;
        end
      end
      ASEL_WAIT: begin
        // R11: latch and flag in the same cycle
        if (convDone) begin
          resultsD = convData;
          eocD     = 1'b1;
          state_d  = ASEL_IDLE;
        end
      end
      default: state_d = ASEL_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      state_q  <= ASEL_IDLE;
      startQ   <= 1'b0;
      eocQ     <= 1'b0;
      resultsQ <= '0;
    end else begin
      state_q  <= state_d;
      startQ   <= startD;
      eocQ     <= eocD;
      resultsQ <= resultsD;
    end
  end

  assign convStart = startQ;
  assign eocPulse  = eocQ;
  assign results   = resultsQ;
  assign busy      = (state_q != ASEL_IDLE);

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_eoc_results;
    @(posedge clk_sys) disable iff (!resetn)
    $rose(eocQ) |-> resultsQ == $past(convData) && $past(convDone);
  endproperty
  a_eoc_results: assert property (p_eoc_results) // R11
    else $error("Results not updated with end of conversion");

  property p_one_start;
    @(posedge clk_sys) disable iff (!resetn)
    startQ |=> !startQ until_with eocQ;
  endproperty
  a_one_start: assert property (p_one_start) // R08
    else $error("Second start issued during a conversion");

  property p_start_cause;
    @(posedge clk_sys) disable iff (!resetn)
    startQ |-> $past(startReq) && $past(state_q == ASEL_IDLE);
  endproperty
  a_start_cause: assert property (p_start_cause) // R08
    else $error("Start issued without an accepted request");

  c_full_conv: cover property (@(posedge clk_sys) disable iff (!resetn)
    startQ ##[1:20] eocQ);

endmodule

// *** hw/asel_top.sv ***
// Purpose: Selects the conversion start source and routes the completion event.
// Assumes: Slot writes and converter signals share clk_sys; trigger and slot
//          strap are pins and are synchronised here.
// Notes:   The initialization word is write only on the slot; its start mode
//          is mirrored on startMode for observation.
//
// Behaviour
// R01: Init bit 14 picks start source.
// R02: Cyclic mode starts on each trigger pulse; the code drops pulses that arrive while a conversion runs.
// R03: Host drives trigger the same for both slots.
// R04: Host may route various signals onto trigger.
// R05: Write mode starts on start-register write.
// R06: Init bit 15 changes nothing.
// R07: Host example value 0x0400 conflicts with bit 14.
// R08: Each start converts four inputs together.
// R09: Bits 8-9 route completion to a line; the code routes by bit 9 and the slot strap only.
// R10: Bits 10-11 enable lines; disabled never asserts.
// R11: Results update together before completion flag.
module asel_top (
  input  wire logic                   clk_sys,
  input  wire logic                   resetn,
  input  wire asel_pkg::asel_wr_s     slotWr,
  input  wire logic                   slotSecond,
  input  wire logic                   trigTwo,
  output logic                        convStart,
  input  wire logic                   convDone,
  input  wire asel_pkg::asel_result_s convData,
  output asel_pkg::asel_result_s      results,
  output logic                        first_interrupt_line,
  output logic                        second_interrupt_line,
  output logic                        startMode,
  output logic                        convBusy
);
  import asel_pkg::*;

  logic [15:0] initQ,     initD;
  logic [2:0]  trigSyncQ, trigSyncD;
  logic [1:0]  slotSyncQ, slotSyncD;
  logic        irqAQ,     irqAD;
  logic        irqBQ,     irqBD;
  logic        trigRise;
  logic        wrStart;
  logic        startReq;
  logic        eoc;
  logic        routeSwap;
  logic        enFirst;
  logic        enSecond;

  function automatic logic hitAddr(asel_wr_s w, logic [ADDR_W-1:0] ofs);
    return w.stb && (w.addr == ofs);
  endfunction

  // ----------------------------------------------------------------
  // Initialization word
  // ----------------------------------------------------------------
  // R06: bit 15 stored, never read
  always_comb begin
    initD = initQ;
    if (hitAddr(slotWr, OFS_INIT)) begin
      initD = slotWr.data;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      initQ <= INIT_RESET;
    end else begin
      initQ <= initD;
    end
  end

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  always_comb begin
    trigSyncD = {trigSyncQ[1:0], trigTwo};
    slotSyncD = {slotSyncQ[0], slotSecond};
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      trigSyncQ <= '0;
      slotSyncQ <= '0;
    end else begin
      trigSyncQ <= trigSyncD;
      slotSyncQ <= slotSyncD;
    end
  end

  // Edge taken between the second and third stage, never the first.
  assign trigRise = trigSyncQ[1] && !trigSyncQ[2];

  // ----------------------------------------------------------------
  // Start source selection
  // ----------------------------------------------------------------
  // R01: mode from bit 14
  assign startMode = initQ[BIT_START_MODE];
  // R05: data of write ignored
  assign wrStart   = hitAddr(slotWr, OFS_START);
  // R02: cyclic trigger pulses
  assign startReq  = startMode ? wrStart : trigRise;

  // R08: one sequencer for all
  asel_conv_seq #(
    .CH_NUM    (NUM_CH)
  ) u_seq (
    .clk_sys   (clk_sys),
    .resetn    (resetn),
    .startReq  (startReq),
    .convStart (convStart),
    .convDone  (convDone),
    .convData  (convData),
    .results   (results),
    .eocPulse  (eoc),
    .busy      (convBusy)
  );

  // ----------------------------------------------------------------
  // Completion routing
  // ----------------------------------------------------------------
  // R09: route by bit 9 and slot
  assign routeSwap = initQ[BIT_ROUTE_HI] ^ slotSyncQ[1];
  // R10: enables follow slot position
  assign enFirst   = slotSyncQ[1] ? initQ[BIT_EN_B] : initQ[BIT_EN_A];
  assign enSecond  = slotSyncQ[1] ? initQ[BIT_EN_A] : initQ[BIT_EN_B];

  always_comb begin
    irqAD = eoc && !routeSwap && enFirst;
    irqBD = eoc &&  routeSwap && enSecond;
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      irqAQ <= 1'b0;
      irqBQ <= 1'b0;
    end else begin
      irqAQ <= irqAD;
      irqBQ <= irqBD;
    end
  end

  assign first_interrupt_line  = irqAQ;
  assign second_interrupt_line = irqBQ;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_mode_load;
    @(posedge clk_sys) disable iff (!resetn)
    hitAddr(slotWr, OFS_INIT) |=> startMode == $past(slotWr.data[BIT_START_MODE]);
  endproperty
  a_mode_load: assert property (p_mode_load) // R01
    else $error("Start mode not taken from bit 14");

  property p_cyc_start;
    @(posedge clk_sys) disable iff (!resetn)
    !startMode && trigRise && !convBusy |=> convStart;
  endproperty
  a_cyc_start: assert property (p_cyc_start) // R02
    else $error("Trigger pulse did not start a conversion");

  property p_wr_start;
    @(posedge clk_sys) disable iff (!resetn)
    startMode && wrStart && !convBusy |=> convStart;
  endproperty
  a_wr_start: assert property (p_wr_start) // R05
    else $error("Start write did not start a conversion");

  property p_no_spurious;
    @(posedge clk_sys) disable iff (!resetn)
    convStart |-> $past(startMode ? wrStart : trigRise);
  endproperty
  a_no_spurious: assert property (p_no_spurious) // R01
    else $error("Conversion started by the unselected source");

  property p_msb_ignored;
    @(posedge clk_sys) disable iff (!resetn)
    hitAddr(slotWr, OFS_INIT) && $stable(slotWr.data[14:0])
      && slotWr.data[14:0] == initQ[14:0] |=> $stable(startMode) && $stable(initQ[14:0]);
  endproperty
  a_msb_ignored: assert property (p_msb_ignored) // R06
    else $error("Bit 15 changed behaviour");

  property p_route;
    @(posedge clk_sys) disable iff (!resetn)
    eoc ##1 $past(enFirst && !routeSwap) |-> first_interrupt_line && !second_interrupt_line;
  endproperty
  a_route: assert property (p_route) // R09
    else $error("Completion not routed to the selected line");

  // Bit 8 is left out of routing on purpose; only bit 9 and the slot strap steer the event.
  property p_route_second;
    @(posedge clk_sys) disable iff (!resetn)
    eoc ##1 $past(enSecond && routeSwap) |-> second_interrupt_line && !first_interrupt_line;
  endproperty
  a_route_second: assert property (p_route_second) // R09
    else $error("Completion not routed to the second line");

  property p_trig_masked;
    @(posedge clk_sys) disable iff (!resetn)
    startMode && !wrStart |=> !convStart;
  endproperty
  a_trig_masked: assert property (p_trig_masked) // R01
    else $error("Conversion started in write mode without a start write");

  property p_disabled;
    @(posedge clk_sys) disable iff (!resetn)
    (first_interrupt_line |-> $past(enFirst)) and (second_interrupt_line |-> $past(enSecond));
  endproperty
  a_disabled: assert property (p_disabled) // R10
    else $error("Disabled interrupt line asserted");

  property p_irq_after_res;
    @(posedge clk_sys) disable iff (!resetn)
    (first_interrupt_line || second_interrupt_line) |-> $past(eoc) && $stable(results);
  endproperty
  a_irq_after_res: assert property (p_irq_after_res) // R11
    else $error("Interrupt raised without fresh results");

  c_cyclic: cover property (@(posedge clk_sys) disable iff (!resetn)
    !startMode && trigRise ##1 convStart ##[1:20] first_interrupt_line);
  c_write: cover property (@(posedge clk_sys) disable iff (!resetn)
    startMode && wrStart ##1 convStart ##[1:20] second_interrupt_line);
  c_slot2: cover property (@(posedge clk_sys) disable iff (!resetn)
    slotSyncQ[1] && eoc);

endmodule

// *** dv/asel_conv_model.sv ***
// Purpose: Behavioural converter that answers each start with one done pulse.
// Assumes: The converter shares clk_sys with the selector.
// Notes:   Data is only valid with done; otherwise it toggles every cycle.
module asel_conv_model
  import asel_pkg::*;
(
  input  wire logic         clk_sys,
  input  wire logic         resetn,
  input  wire logic         convStart,
  input  wire logic         slow,
  input  wire asel_result_s nextData,
  output logic              convDone,
  output asel_result_s      convData
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt;
  // ----------------------------------------------------------------
  // Conversion timing
  // ----------------------------------------------------------------
  // all four together
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      cnt <= 0;
      convDone <= 1'b0;
      convData <= '0;
    end else begin
      convDone <= 1'b0;
      // Toggling keeps a stale sample from passing for a fresh one.
      convData <= ~convData;
      if (convStart) begin
        cnt <= slow ? 12 : 1;
      end else if (cnt > 1) begin
        cnt <= cnt - 1;
      end else if (cnt == 1) begin
        cnt <= 0;
        convDone <= 1'b1;
        convData <= nextData;
      end
    end
  end
endmodule

// *** dv/tb_asel_top.sv ***
// Purpose: Random and corner checks of start selection and completion routing.
// Assumes: Inputs change on the falling edge of clk_sys.
// Notes:   Expected routing and start counts are derived in bench functions.
module tb_asel_top;
  import asel_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys, resetn, slotSecond, trigTwo, convStart, convDone, slow;
  logic firstLine, secondLine, startMode, convBusy;
  asel_wr_s slotWr;
  asel_result_s convData, results, nextData;
  int miscompares, n_checks, nStart, nFirst, nSecond;
  logic [31:0] seed;
  logic [15:0] w;
  asel_top dut (.clk_sys(clk_sys), .resetn(resetn), .slotWr(slotWr),
    .slotSecond(slotSecond), .trigTwo(trigTwo), .convStart(convStart),
    .convDone(convDone), .convData(convData), .results(results),
    .first_interrupt_line(firstLine), .second_interrupt_line(secondLine),
    .startMode(startMode), .convBusy(convBusy));
  asel_conv_model conv (.clk_sys(clk_sys), .resetn(resetn), .convStart(convStart),
    .slow(slow), .nextData(nextData), .convDone(convDone), .convData(convData));
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    nStart += int'(convStart === 1'b1);
    nFirst += int'(firstLine === 1'b1);
    nSecond += int'(secondLine === 1'b1);
  end
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // expected line pulses as {second, first}.
  function automatic logic [1:0] expLines(logic slot2, logic [15:0] v);
    logic en;
    en = v[BIT_ROUTE_HI] ? v[BIT_EN_B] : v[BIT_EN_A];
    return (slot2 == v[BIT_ROUTE_HI]) ? {1'b0, en} : {en, 1'b0};
  endfunction
  task automatic end_of_test();
    $display("checks %0d, mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic check(logic [47:0] seen, logic [47:0] exp);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(logic [4:0] a, logic [15:0] d);
    @(negedge clk_sys);
    slotWr = '{stb: 1'b1, addr: a, data: d};
    @(negedge clk_sys);
    slotWr.stb = 1'b0;
  endtask
  // Issues one trigger pulse, or one or two start writes, then checks its outcome.
  task automatic kick(logic viaWrite, logic twice);
    int s0, f0, q0, k;
    logic go;
    logic [1:0] el;
    s0 = nStart;
    f0 = nFirst;
    q0 = nSecond;
    nextData = 48'({rnd(), rnd()});
    go = (viaWrite == w[BIT_START_MODE]);
    if (viaWrite) begin
      // data of the start write is random
      wr(OFS_START, 16'(rnd()));
      if (twice) wr(OFS_START, 16'(rnd()));
    end else begin
      // trigger held high then low for three cycles
      @(negedge clk_sys) trigTwo = 1'b1;
      repeat (3) @(negedge clk_sys);
      trigTwo = 1'b0;
      repeat (3) @(negedge clk_sys);
    end
    repeat (2) @(negedge clk_sys);
    for (k = 0; k < 40 && convBusy !== 1'b0; k++) @(negedge clk_sys);
    if (k == 40) begin
      miscompares++;
      end_of_test();
    end
    repeat (4) @(negedge clk_sys);
    el = go ? expLines(slotSecond, w) : 2'b00;
    check(48'(nStart - s0), 48'(go));
    check(48'(nFirst - f0), 48'(el[0]));
    check(48'(nSecond - q0), 48'(el[1]));
    if (go) check(results, nextData);
  endtask
  initial begin
    seed = 32'h0000C67E;
    miscompares = 0;
    n_checks = 0;
    slotWr = '0;
    slotSecond = 1'b0;
    trigTwo = 1'b0;
    slow = 1'b0;
    nextData = '0;
    w = INIT_RESET;
    resetn = 1'b0;
    repeat (16) @(negedge clk_sys);
    check(48'({startMode, convStart, convBusy, firstLine, secondLine}), 48'h0);
    resetn = 1'b1;
    repeat (3) @(negedge clk_sys);
    for (int i = 0; i < 24; i++) begin
      w = 16'(rnd());
      w[BIT_ROUTE_HI] = i[0];
      w[BIT_EN_A] = i[1];
      w[BIT_EN_B] = i[2];
      // the host example word selects cyclic starts
      if (i == 16) w = 16'h0400;
      // top bit set or clear changes nothing
      if (i == 17) w = 16'hCC00;
      if (i == 18) w = 16'h4C00;
      @(negedge clk_sys) slotSecond = i[3];
      slow = i[1] ^ i[3];
      wr(OFS_INIT, w);
      // rewrite with only the top bit flipped
      if (i[4]) wr(OFS_INIT, w ^ 16'h8000);
      repeat (3) @(negedge clk_sys);
      check(48'(startMode), 48'(w[BIT_START_MODE]));
      kick(1'b0, 1'b0);
      kick(1'b1, slow);
    end
    end_of_test();
  end
endmodule
